// File: inc/rst_seq_regs.vh
// constants for the post-reset start-up sequencer and service pin
// Behaviour
// - allow 15 clock transitions for stabilisation
// - steps run in one fixed order
// - self-test 200000 internal, 425000 external
// - boot state init 2275000, or 70000+25ms*E
// - external RAM test-and-clear: 24000+214 per byte
// - clear-only 24000+152 per byte; internal zero
// - seed at most 50000 external, internal none
// - system RAM 21000+600B or 27000+1500B
// - comm port and internal seed cost zero
// - no-boot checksum 3400/7200 plus 175 per byte
// - external boot to app: 82000+100ms+175M
// - one-second timer init takes 6100 cycles
// - scheduler at least 7400, longer otherwise
// - service pin alternates at 76 Hz, half each
// - input-only service pin gets selectable pull-up
// - pull-up enabled unless explicitly disabled
// - unconfigured node drives pin low, LED lit
// - held-low pin sends 48-bit identifier message
// - pin level ignored while reset asserted
`ifndef RST_SEQ_REGS_VH
`define RST_SEQ_REGS_VH

// clock and time units
`define CLK_HZ 100000000
`define CLK_CYC_PER_MS 100000
`define SVC_RATE_HZ 76
`define BOOT_BYTE_MS 25
`define CSUM_BOOT_MS 100

// step budgets, cycles of the input clock
`define CYC_STAB 32'd15
`define CYC_SELFTEST_INT 200000
`define CYC_SELFTEST_EXT 425000
`define CYC_SVC_INIT 32'd1000
`define CYC_STATE_NOBOOT_INT 32'd250
`define CYC_STATE_NOBOOT_EXT 32'd1300
`define CYC_STATE_BOOT_INT 2275000
`define CYC_STATE_BOOT_EXT 70000
`define CYC_XRAM_BASE 24000
`define CYC_XRAM_TEST_BYTE 32'd214
`define CYC_XRAM_CLEAR_BYTE 32'd152
`define CYC_SEED_EXT 50000
`define CYC_SYSRAM_INT 21000
`define CYC_SYSRAM_EXT 27000
`define CYC_SYSRAM_BUF_INT 32'd600
`define CYC_SYSRAM_BUF_EXT 32'd1500
`define CYC_CSUM_INT 32'd3400
`define CYC_CSUM_EXT 7200
`define CYC_CSUM_BOOT 82000
`define CYC_CSUM_BYTE 32'd175
`define CYC_TIMER 6100
`define CYC_SCHED 7400

// boot byte count limits
`define BOOT_BYTES_MIN 9'd10
`define BOOT_BYTES_MAX 9'd504

// service pin: cycles after turning to input before sampling
`define SVC_SETTLE 20'h00004

`endif

// File: logic/service_pin.v
// service pin driver: input/open-drain alternation, pull-up and sampling
`include "rst_seq_regs.vh"

module service_pin #(
  parameter HALF_CYCLES = 657894,
  parameter CW = 20
) (
  // clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // control from the sequencer
  input wire alt_en_i,
  input wire drive_low_i,
  input wire input_only_i,
  input wire pullup_off_i,
  // pin
  input wire svc_pin_i,
  output wire svc_pin_o,
  output wire svc_pin_oe_o,
  output wire pullup_en_o,
  // sampled level
  output reg level_valid_o,
  output reg level_low_o
);

  reg [CW-1:0] phase_cnt_reg;
  reg drive_phase_reg;
  reg sync1_reg;
  reg sync2_reg;
  wire alternating;

  assign alternating = alt_en_i & ~input_only_i;

  // half-period counter; each role lasts HALF_CYCLES
  // 76 Hz alternation
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase_cnt_reg <= {CW{1'b0}};
      drive_phase_reg <= 1'b0;
    end
    else if (!alternating)
    begin
      phase_cnt_reg <= {CW{1'b0}};
      drive_phase_reg <= 1'b0;
    end
    else if (phase_cnt_reg == HALF_CYCLES[CW-1:0] - 1'b1)
    begin
      phase_cnt_reg <= {CW{1'b0}};
      drive_phase_reg <= ~drive_phase_reg;
    end
    else
    begin
      phase_cnt_reg <= phase_cnt_reg + 1'b1;
    end
  end

  // open drain: only ever drives low, and only in the output half
  // LED low drive
  assign svc_pin_o = 1'b0;
  assign svc_pin_oe_o = alternating & drive_phase_reg & drive_low_i;

  // pull-up only when the pin is purely an input
  // selectable pull-up
  assign pullup_en_o = input_only_i & ~pullup_off_i;

  // two-flop synchroniser; resets high so no false press after reset
  // reset level ignored
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= svc_pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  // sample only well into the input half, so our own low is never seen
  // input-phase sampling
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      level_valid_o <= 1'b0;
      level_low_o <= 1'b0;
    end
    else
    begin
      level_valid_o <= 1'b0;
      if (input_only_i || (alternating && !drive_phase_reg && phase_cnt_reg >= `SVC_SETTLE))
      begin
        level_valid_o <= 1'b1;
        level_low_o <= ~sync2_reg;
      end
    end
  end

endmodule // service_pin

// File: logic/reset_sequencer.v
// post-reset start-up sequencer with service pin handling
`include "rst_seq_regs.vh"

module reset_sequencer #(
  parameter SELFTEST_INT = `CYC_SELFTEST_INT,
  parameter SELFTEST_EXT = `CYC_SELFTEST_EXT,
  parameter STATE_BOOT_INT = `CYC_STATE_BOOT_INT,
  parameter STATE_BOOT_EXT = `CYC_STATE_BOOT_EXT,
  parameter BOOT_BYTE_CYC = `BOOT_BYTE_MS * `CLK_CYC_PER_MS,
  parameter XRAM_BASE = `CYC_XRAM_BASE,
  parameter SEED_EXT = `CYC_SEED_EXT,
  parameter SYSRAM_INT = `CYC_SYSRAM_INT,
  parameter SYSRAM_EXT = `CYC_SYSRAM_EXT,
  parameter CSUM_EXT = `CYC_CSUM_EXT,
  parameter CSUM_BOOT = `CYC_CSUM_BOOT,
  parameter CSUM_BOOT_CYC = `CSUM_BOOT_MS * `CLK_CYC_PER_MS,
  parameter TIMER_CYC = `CYC_TIMER,
  parameter SCHED_CYC = `CYC_SCHED,
  parameter SVC_HALF = `CLK_HZ / (2 * `SVC_RATE_HZ)
) (
  // clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // configuration, caught once after reset release
  input wire ext_mem_i,
  input wire boot_req_i,
  input wire boot_to_app_i,
  input wire [8:0] boot_bytes_i,
  input wire xram_test_i,
  input wire [15:0] xram_bytes_i,
  input wire [15:0] xram_free_bytes_i,
  input wire [7:0] buffers_i,
  input wire [15:0] csum_bytes_i,
  input wire [31:0] sched_extra_i,
  // runtime node state
  input wire node_configured_i,
  input wire svc_input_only_i,
  input wire svc_pullup_off_i,
  input wire [47:0] unique_id_i,
  // service pin
  input wire svc_pin_i,
  output wire svc_pin_o,
  output wire svc_pin_oe_o,
  output wire svc_pullup_en_o,
  // sequence status
  output wire [3:0] step_o,
  output wire seq_done_o,
  output wire net_ready_o,
  // identifier message
  output reg svc_msg_valid_o,
  output reg [47:0] svc_msg_id_o
);

  // step codes, in execution order
  localparam S_LATCH = 4'h0;
  localparam S_STAB = 4'h1;
  localparam S_SELFTEST = 4'h2;
  localparam S_SVC_INIT = 4'h3;
  localparam S_STATE = 4'h4;
  localparam S_XRAM = 4'h5;
  localparam S_SEED = 4'h6;
  localparam S_SYSRAM = 4'h7;
  localparam S_COMM = 4'h8;
  localparam S_CSUM = 4'h9;
  localparam S_TIMER = 4'ha;
  localparam S_SCHED = 4'hb;
  localparam S_DONE = 4'hc;

  reg [3:0] step_reg;
  reg [3:0] step_next;
  reg [31:0] count_reg;
  reg [31:0] count_next;
  reg [31:0] budget;

  // captured configuration
  reg ext_reg;
  reg boot_reg;
  reg boot_app_reg;
  reg [8:0] boot_bytes_reg;
  reg xram_test_reg;
  reg [15:0] xram_bytes_reg;
  reg [15:0] xram_free_reg;
  reg [7:0] buffers_reg;
  reg [15:0] csum_bytes_reg;
  reg [31:0] sched_extra_reg;

  // service request edge tracking
  reg press_prev_reg;
  wire level_valid;
  wire level_low;
  wire svc_alt;
  wire svc_led;

  // 32-bit product of a count and a per-unit cost
  function [31:0] mul32;
    input [31:0] a;
    input [31:0] b;
    begin
      mul32 = a * b;
    end
  endfunction

  // boot byte count held inside its legal range
  function [8:0] clamp_boot;
    input [8:0] e;
    begin
      if (e < `BOOT_BYTES_MIN)
        clamp_boot = `BOOT_BYTES_MIN;
      else if (e > `BOOT_BYTES_MAX)
        clamp_boot = `BOOT_BYTES_MAX;
      else
        clamp_boot = e;
    end
  endfunction

  // cycle budget for one step, from captured configuration
  function [31:0] step_budget;
    input [3:0] s;
    begin
      case (s)
        S_STAB: step_budget = `CYC_STAB;
        S_SELFTEST: step_budget = ext_reg ? SELFTEST_EXT[31:0] : SELFTEST_INT[31:0];
        S_SVC_INIT: step_budget = `CYC_SVC_INIT;
        S_STATE:
        begin
          if (!boot_reg)
            step_budget = ext_reg ? `CYC_STATE_NOBOOT_EXT : `CYC_STATE_NOBOOT_INT;
          else if (!ext_reg)
            step_budget = STATE_BOOT_INT[31:0];
          else
            step_budget = STATE_BOOT_EXT[31:0] +
              mul32({23'h0, clamp_boot(boot_bytes_reg)}, BOOT_BYTE_CYC[31:0]);
        end
        S_XRAM:
        begin
          if (!ext_reg || xram_bytes_reg == 16'h0000)
            step_budget = 32'h0000_0000;
          else if (xram_test_reg)
            step_budget = XRAM_BASE[31:0] +
              mul32({16'h0, xram_bytes_reg}, `CYC_XRAM_TEST_BYTE);
          else
            step_budget = XRAM_BASE[31:0] +
              mul32({16'h0, xram_free_reg}, `CYC_XRAM_CLEAR_BYTE);
        end
        S_SEED: step_budget = ext_reg ? SEED_EXT[31:0] : 32'h0000_0000;
        S_SYSRAM:
        begin
          if (ext_reg)
            step_budget = SYSRAM_EXT[31:0] +
              mul32({24'h0, buffers_reg}, `CYC_SYSRAM_BUF_EXT);
          else
            step_budget = SYSRAM_INT[31:0] +
              mul32({24'h0, buffers_reg}, `CYC_SYSRAM_BUF_INT);
        end
        S_COMM: step_budget = 32'h0000_0000;
        S_CSUM:
        begin
          if (!ext_reg)
            step_budget = `CYC_CSUM_INT + mul32({16'h0, csum_bytes_reg}, `CYC_CSUM_BYTE);
          else if (boot_reg && boot_app_reg)
            step_budget = CSUM_BOOT[31:0] + CSUM_BOOT_CYC[31:0] +
              mul32({16'h0, csum_bytes_reg}, `CYC_CSUM_BYTE);
          else
            step_budget = CSUM_EXT[31:0] + mul32({16'h0, csum_bytes_reg}, `CYC_CSUM_BYTE);
        end
        S_TIMER: step_budget = TIMER_CYC[31:0];
        S_SCHED: step_budget = SCHED_CYC[31:0] + sched_extra_reg;
        default: step_budget = 32'h0000_0000;
      endcase
    end
  endfunction

  // configuration is caught by a clocked process after release, never by reset
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ext_reg <= 1'b0;
      boot_reg <= 1'b0;
      boot_app_reg <= 1'b0;
      boot_bytes_reg <= 9'h000;
      xram_test_reg <= 1'b0;
      xram_bytes_reg <= 16'h0000;
      xram_free_reg <= 16'h0000;
      buffers_reg <= 8'h00;
      csum_bytes_reg <= 16'h0000;
      sched_extra_reg <= 32'h0000_0000;
    end
    else if (step_reg == S_LATCH)
    begin
      ext_reg <= ext_mem_i;
      boot_reg <= boot_req_i;
      boot_app_reg <= boot_to_app_i;
      boot_bytes_reg <= boot_bytes_i;
      xram_test_reg <= xram_test_i;
      xram_bytes_reg <= xram_bytes_i;
      xram_free_reg <= xram_free_bytes_i;
      buffers_reg <= buffers_i;
      csum_bytes_reg <= csum_bytes_i;
      sched_extra_reg <= sched_extra_i;
    end
  end

  // budget of the step about to be entered
  always @*
  begin
    budget = step_budget(step_reg + 4'h1);
  end

  // step sequencing on a single down-counter; zero budget still takes one cycle
  // down-counter sequencing
  always @*
  begin
    step_next = step_reg;
    count_next = count_reg;
    case (step_reg)
      S_LATCH:
      begin
        // capture happens this cycle, so the first budget is fixed here
        step_next = S_STAB;
        count_next = `CYC_STAB - 32'h1;
      end
      S_DONE:
      begin
        step_next = S_DONE;
        count_next = 32'h0000_0000;
      end
      default:
      begin
        if (count_reg == 32'h0000_0000)
        begin
          step_next = step_reg + 4'h1;
          count_next = (budget == 32'h0000_0000) ? 32'h0000_0000 : budget - 32'h1;
        end
        else
        begin
          count_next = count_reg - 32'h1;
        end
      end
    endcase
  end

  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      step_reg <= S_LATCH;
      count_reg <= 32'h0000_0000;
    end
    else
    begin
      step_reg <= step_next;
      count_reg <= count_next;
    end
  end

  assign step_o = step_reg;
  assign seq_done_o = (step_reg == S_DONE);
  // network side takes packets once the timer step has finished
  assign net_ready_o = (step_reg > S_TIMER);

  // pin oscillates during self-test, is off during later init, then runs
  // alternation windows
  assign svc_alt = (step_reg == S_SELFTEST) || (step_reg == S_DONE);
  assign svc_led = (step_reg == S_SELFTEST) || !node_configured_i;

  service_pin #(
    .HALF_CYCLES(SVC_HALF),
    .CW(20)
  ) u_service_pin (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .alt_en_i(svc_alt),
    .drive_low_i(svc_led),
    .input_only_i(svc_input_only_i),
    .pullup_off_i(svc_pullup_off_i),
    .svc_pin_i(svc_pin_i),
    .svc_pin_o(svc_pin_o),
    .svc_pin_oe_o(svc_pin_oe_o),
    .pullup_en_o(svc_pullup_en_o),
    .level_valid_o(level_valid),
    .level_low_o(level_low)
  );

  // one message per press: a new low after a seen high or after reset, once running
  // identifier message
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      press_prev_reg <= 1'b0;
      svc_msg_valid_o <= 1'b0;
      svc_msg_id_o <= 48'h0000_0000_0000;
    end
    else
    begin
      svc_msg_valid_o <= 1'b0;
      if (level_valid && step_reg == S_DONE)
      begin
        press_prev_reg <= level_low;
        if (level_low && !press_prev_reg)
        begin
          svc_msg_valid_o <= 1'b1;
          svc_msg_id_o <= unique_id_i;
        end
      end
    end
  end

endmodule // reset_sequencer

// File: tb/reset_sequencer_properties.sv
// concurrent checks on the start-up sequencer and service pin ports
module reset_sequencer_checker #(
  parameter int SVC_HALF = 40
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // live node state
  input wire logic node_configured_i,
  input wire logic svc_input_only_i,
  input wire logic svc_pullup_off_i,
  // outputs under watch
  input wire logic svc_pin_o,
  input wire logic svc_pin_oe_o,
  input wire logic svc_pullup_en_o,
  input wire logic [3:0] step_o,
  input wire logic seq_done_o,
  input wire logic net_ready_o,
  input wire logic svc_msg_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [31:0] oe_run_reg;

  // length of the current low-drive run, so one output half can be bounded
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      oe_run_reg <= 32'h0;
    else
      oe_run_reg <= svc_pin_oe_o ? oe_run_reg + 32'h1 : 32'h0;
  end

  property p_stab_len;
    step_o == 4'h2 && $past(step_o) == 4'h1 |->
      $past(step_o, 15) == 4'h1 && $past(step_o, 16) == 4'h0;
  endproperty
  a_stab_len: assert property (p_stab_len) else $error("stabilise step length wrong");
  property p_step_order;
    step_o != $past(step_o) |-> step_o == $past(step_o) + 4'h1 && step_o <= 4'hc;
  endproperty
  a_step_order: assert property (p_step_order) else $error("step skipped or reversed");
  property p_done;
    seq_done_o == (step_o == 4'hc);
  endproperty
  a_done: assert property (p_done) else $error("done flag disagrees with step");
  property p_ready;
    net_ready_o == (step_o > 4'ha);
  endproperty
  a_ready: assert property (p_ready) else $error("network ready before timer init");
  property p_open_drain;
    svc_pin_oe_o |-> svc_pin_o == 1'b0 && oe_run_reg < SVC_HALF;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin drive not a low half");
  property p_pullup;
    svc_pullup_en_o == (svc_input_only_i && !svc_pullup_off_i);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up enable wrong");
  property p_input_only;
    svc_input_only_i && $past(svc_input_only_i) |-> !svc_pin_oe_o;
  endproperty
  a_input_only: assert property (p_input_only) else $error("input-only pin driven");
  property p_dark;
    step_o == 4'hc && node_configured_i && $past(node_configured_i) |-> !svc_pin_oe_o;
  endproperty
  a_dark: assert property (p_dark) else $error("led lit on configured node");
  property p_drive_steps;
    svc_pin_oe_o |-> step_o == 4'h2 || step_o == 4'hc || $past(step_o) == 4'h2;
  endproperty
  a_drive_steps: assert property (p_drive_steps) else $error("pin driven outside its steps");
  property p_msg;
    svc_msg_valid_o |-> seq_done_o && $past(seq_done_o) ##1 !svc_msg_valid_o;
  endproperty
  a_msg: assert property (p_msg) else $error("message pulse malformed");
endmodule // reset_sequencer_checker

bind reset_sequencer reset_sequencer_checker #(.SVC_HALF(SVC_HALF)) reset_sequencer_checker_inst (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .node_configured_i(node_configured_i),
  .svc_input_only_i(svc_input_only_i), .svc_pullup_off_i(svc_pullup_off_i),
  .svc_pin_o(svc_pin_o), .svc_pin_oe_o(svc_pin_oe_o), .svc_pullup_en_o(svc_pullup_en_o),
  .step_o(step_o), .seq_done_o(seq_done_o), .net_ready_o(net_ready_o),
  .svc_msg_valid_o(svc_msg_valid_o));

// File: tb/svc_button_led.sv
// push-button and indicator led on the open-drain service pin
module svc_button_led (
  // button and pin
  input wire logic press_i,
  input wire logic pin_oe_i,
  input wire logic pin_drv_i,
  output logic pin_o,
  output logic led_on_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign led_on_o = pin_oe_i && !pin_drv_i;
  // button grounds pin
  // a released pin rises through the led and its resistor, never floats
  assign pin_o = (led_on_o || press_i) ? 1'b0 : 1'b1;
endmodule // svc_button_led

// File: tb/reset_sequencer_tb_top.sv
// self-checking bench for the start-up sequencer and service pin
module reset_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened budgets; fixed per-unit figures stay as built
  localparam int HALF = 40, ST_I = 50, ST_E = 60, SB_I = 50, SB_E = 30, BBC = 3, XB = 20;
  localparam int SE = 20, SR_I = 20, SR_E = 25, CB = 40, CBC = 10, TC = 10, SC = 10;
  typedef struct {int ext, boot, app, e, xt, r, ra, b, m, x;} row_t;
  // variant, boot, to-app, E, test, R, Ra, B, M, extra scheduler cycles
  row_t rows[5] = '{'{0, 0, 0, 10, 0, 0, 0, 2, 4, 0}, '{0, 1, 1, 10, 0, 0, 0, 1, 0, 5},
    '{1, 0, 0, 10, 1, 8, 0, 1, 2, 0}, '{1, 1, 1, 3, 0, 8, 5, 1, 1, 3},
    '{1, 1, 0, 511, 1, 0, 0, 0, 0, 0}};
  logic core_clk_i, resetn_i, ext_mem_i, boot_req_i, boot_to_app_i, xram_test_i, press;
  logic node_configured_i, svc_input_only_i, svc_pullup_off_i, svc_pin, svc_pin_o;
  logic svc_pin_oe_o, svc_pullup_en_o, seq_done_o, net_ready_o, svc_msg_valid_o;
  logic [8:0] boot_bytes_i;
  logic [15:0] xram_bytes_i, xram_free_bytes_i, csum_bytes_i;
  logic [7:0] buffers_i;
  logic [31:0] sched_extra_i;
  logic [47:0] unique_id_i, svc_msg_id_o, last_id;
  logic [3:0] step_o;
  int fail_count, check_count, oe_hits, msg_hits, n;
  int dur[16];

  reset_sequencer #(.SELFTEST_INT(ST_I), .SELFTEST_EXT(ST_E), .STATE_BOOT_INT(SB_I),
    .STATE_BOOT_EXT(SB_E), .BOOT_BYTE_CYC(BBC), .XRAM_BASE(XB), .SEED_EXT(SE),
    .SYSRAM_INT(SR_I), .SYSRAM_EXT(SR_E), .CSUM_BOOT(CB), .CSUM_BOOT_CYC(CBC),
    .TIMER_CYC(TC), .SCHED_CYC(SC), .SVC_HALF(HALF)) reset_sequencer_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ext_mem_i(ext_mem_i),
    .boot_req_i(boot_req_i), .boot_to_app_i(boot_to_app_i), .boot_bytes_i(boot_bytes_i),
    .xram_test_i(xram_test_i), .xram_bytes_i(xram_bytes_i),
    .xram_free_bytes_i(xram_free_bytes_i), .buffers_i(buffers_i), .csum_bytes_i(csum_bytes_i),
    .sched_extra_i(sched_extra_i), .node_configured_i(node_configured_i),
    .svc_input_only_i(svc_input_only_i), .svc_pullup_off_i(svc_pullup_off_i),
    .unique_id_i(unique_id_i), .svc_pin_i(svc_pin), .svc_pin_o(svc_pin_o),
    .svc_pin_oe_o(svc_pin_oe_o), .svc_pullup_en_o(svc_pullup_en_o), .step_o(step_o),
    .seq_done_o(seq_done_o), .net_ready_o(net_ready_o), .svc_msg_valid_o(svc_msg_valid_o),
    .svc_msg_id_o(svc_msg_id_o));
  svc_button_led svc_button_led_inst (.press_i(press), .pin_oe_i(svc_pin_oe_o),
    .pin_drv_i(svc_pin_o), .pin_o(svc_pin), .led_on_o());

  // free-running core clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // expected length of step k; a zero budget still costs one cycle
  function automatic int blen(input row_t r, input int k);
    int v;
    int e;
    e = r.e < 10 ? 10 : (r.e > 504 ? 504 : r.e);
    case (k)
      1: v = 15;
      2: v = r.ext ? ST_E : ST_I;
      3: v = 1000;
      4: v = r.boot ? (r.ext ? SB_E + e * BBC : SB_I) : (r.ext ? 1300 : 250);
      5: v = (!r.ext || r.r == 0) ? 0 : (r.xt ? XB + 214 * r.r : XB + 152 * r.ra);
      6: v = r.ext ? SE : 0;
      7: v = r.ext ? SR_E + 1500 * r.b : SR_I + 600 * r.b;
      8: v = 0;
      9: v = !r.ext ? 3400 + 175 * r.m : (r.boot && r.app ? CB + CBC : 7200) + 175 * r.m;
      10: v = TC;
      default: v = SC + r.x;
    endcase
    return v < 1 ? 1 : v;
  endfunction

  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok)
    begin
      fail_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // inputs always change one small delay after the rising edge
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic watch(input int cyc);
    repeat (cyc)
    begin
      tick();
      oe_hits += (svc_pin_oe_o !== 1'b0);
      if (svc_msg_valid_o !== 1'b0)
      begin
        msg_hits++;
        last_id = svc_msg_id_o;
      end
    end
  endtask

  // bounded run of one pin-drive level; a run reaching 200 cycles is reported as a stuck pin
  task automatic run_len(input logic lvl, output int cnt);
    cnt = 0;
    while (svc_pin_oe_o === lvl && cnt < 200)
    begin
      tick();
      cnt++;
    end
    if (cnt == 200)
      chk(1'b0, "pin level stuck");
  endtask

  task automatic run_seq(input row_t r);
    int k;
    int c;
    int rdy_bad;
    resetn_i = 1'b0;
    rdy_bad = 0;
    {ext_mem_i, boot_req_i, boot_to_app_i, xram_test_i} = {r.ext[0], r.boot[0], r.app[0], r.xt[0]};
    {boot_bytes_i, xram_bytes_i, xram_free_bytes_i} = {r.e[8:0], r.r[15:0], r.ra[15:0]};
    {buffers_i, csum_bytes_i, sched_extra_i} = {r.b[7:0], r.m[15:0], r.x};
    dur = '{default: 0};
    oe_hits = 0;
    repeat (5) tick();
    chk({step_o, seq_done_o, svc_pin_oe_o, svc_msg_valid_o} === 7'h00, "reset state");
    resetn_i = 1'b1;
    for (c = 0; c < 60000 && seq_done_o !== 1'b1; c++)
    begin
      tick();
      dur[step_o]++;
      // network side may only take packets once the timer step is over
      rdy_bad += (net_ready_o !== (step_o >= 4'hb));
      if (step_o == 4'h2)
        oe_hits += (svc_pin_oe_o === 1'b1);
    end
    chk(seq_done_o === 1'b1, "sequence never finished");
    if (seq_done_o !== 1'b1)
      test_done();
    chk(oe_hits == blen(r, 2) - HALF, "self-test pin drive");
    chk(rdy_bad == 0, "network ready timing");
    for (k = 1; k < 12; k++)
      chk(dur[k] == blen(r, k), $sformatf("step %0d took %0d", k, dur[k]));
  endtask

  initial
  begin
    {resetn_i, press, node_configured_i, svc_input_only_i, svc_pullup_off_i} = 5'h04;
    unique_id_i = 48'h5a3c_9e17_b2d4;
    fail_count = 0;
    check_count = 0;
    // every variant and boot path, order and budgets of each step
    foreach (rows[i])
      run_seq(rows[i]);
    // unconfigured node: equal halves, led lit through each output half
    node_configured_i = 1'b0;
    run_len(1'b0, n);
    run_len(1'b1, n);
    run_len(1'b0, n);
    chk(n == HALF, "input half length");
    run_len(1'b1, n);
    chk(n == HALF, "led half length");
    // press inside an input half; own low drive must not add messages
    repeat (6) tick();
    press = 1'b1;
    msg_hits = 0;
    watch(10);
    press = 1'b0;
    watch(2 * HALF);
    chk(msg_hits == 1 && last_id === unique_id_i, "identifier message");
    node_configured_i = 1'b1;
    tick();
    oe_hits = 0;
    watch(2 * HALF + 4);
    chk(oe_hits == 0, "led lit on configured node");
    // input-only pin: never driven, pull-up on until disabled, always sampled
    svc_input_only_i = 1'b1;
    node_configured_i = 1'b0;
    press = 1'b1;
    msg_hits = 0;
    watch(8);
    press = 1'b0;
    watch(2 * HALF);
    chk(oe_hits == 0 && msg_hits == 1 && svc_pullup_en_o === 1'b1, "input-only pin");
    svc_pullup_off_i = 1'b1;
    tick();
    chk(svc_pullup_en_o === 1'b0, "pull-up disable");
    // button pressed while reset is held gives no message
    resetn_i = 1'b0;
    press = 1'b1;
    watch(6);
    chk(msg_hits == 1 && step_o === 4'h0, "pin ignored in reset");
    test_done();
  end
endmodule // reset_sequencer_tb_top
